//--- rtl/ssa_pkg.sv
// Package: constants and types shared by both serial-bus ends
package ssa_pkg;
	localparam int SSA_CLK_HZ = 125000000;
	localparam int SSA_TIMEOUT_MS = 35;
	localparam int SSA_TIMEOUT_CYC = SSA_CLK_HZ / 1000 * SSA_TIMEOUT_MS;
	localparam int SSA_SUPPLY_MS = 2;
	localparam int SSA_SUPPLY_CYC = SSA_CLK_HZ / 1000 * SSA_SUPPLY_MS;
	localparam logic [6:0] SSA_ARA_ADDR = 7'h0c;
	localparam logic [6:0] SSA_DEV_ADDR_RST = 7'h20;
	localparam logic [7:0] SSA_CFG1_OFF = 8'hd1;
	localparam int SSA_CFG1_TO_BIT = 3;
	localparam logic [7:0] SSA_CFG1_RST = 8'h00;
	localparam logic [7:0] SSA_CMD_CLEAR = 8'h03;
	localparam logic [7:0] SSA_STATUS_BYTE_OFF = 8'h78;
	localparam logic [7:0] SSA_STATUS_WORD_OFF = 8'h79;
	localparam logic [7:0] SSA_MASK_OFF = 8'h1b;
	localparam logic [7:0] SSA_BLOCK_OFF = 8'h30;
	localparam int SSA_STB_EXCL_BIT = 6;
	localparam int SSA_STW_EXCL_BIT = 11;
	localparam logic [15:0] SSA_MASK_RST = 16'h0000;
	localparam int SSA_HALF_BIT = 10;
	// Host register map (Avalon byte addresses)
	localparam logic [3:0] SSA_H_CTRL = 4'h0;
	localparam logic [3:0] SSA_H_WDATA = 4'h4;
	localparam logic [3:0] SSA_H_STAT = 4'h8;
	localparam logic [3:0] SSA_H_RDATA = 4'hc;
	localparam int SSA_H_MAXB = 4;
	typedef enum logic [2:0] {
		SSA_OP_SEND, SSA_OP_WWORD, SSA_OP_WBLOCK, SSA_OP_RBYTE,
		SSA_OP_RWORD, SSA_OP_RBLOCK, SSA_OP_ARA
	} ssa_op_t;
endpackage

//--- rtl/ssa_if.sv
// Interface: open-drain two-wire link between host and device
`timescale 1ns/1ns
interface ssa_if;
	logic scl_host_oe;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic alert_dev_oe;
	wire logic scl = ~scl_host_oe;
	wire logic sda = ~(sda_host_oe | sda_dev_oe);
	wire logic alert_n = ~alert_dev_oe;
	modport host (output scl_host_oe, output sda_host_oe,
		input scl, input sda, input alert_n);
	modport dev (output sda_dev_oe, output alert_dev_oe,
		input scl, input sda);
endinterface

//--- rtl/ssa_sync.sv
// Two-flop synchroniser with edge and condition detection
`timescale 1ns/1ns
module ssa_sync
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det,
	output logic activity
);
	logic [1:0] m1_q;
	logic [1:0] m2_q;
	logic [1:0] m3_q;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			m1_q <= 2'h3;
			m2_q <= 2'h3;
			m3_q <= 2'h3;
		end
		else
		begin
			m1_q <= {scl_in, sda_in};
			m2_q <= m1_q;
			m3_q <= m2_q;
		end
	end
	assign scl_s = m2_q[1];
	assign sda_s = m2_q[0];
	assign scl_rise = m2_q[1] & ~m3_q[1];
	assign scl_fall = ~m2_q[1] & m3_q[1];
	assign start_det = m2_q[1] & m3_q[1] & ~m2_q[0] & m3_q[0];
	assign stop_det = m2_q[1] & m3_q[1] & m2_q[0] & ~m3_q[0];
	assign activity = m2_q != m3_q;
endmodule

//--- rtl/ssa_dev.sv
// Device end: serial slave with status alert and bus timeout
//
// Design decision made here: the register reads and writes over the serial link.
`timescale 1ns/1ns
module ssa_dev
#(
	parameter int TIMEOUT_CYC = ssa_pkg::SSA_TIMEOUT_CYC,
	parameter logic [6:0] DEV_ADDR = ssa_pkg::SSA_DEV_ADDR_RST
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	ssa_if.dev link,
	input wire logic [7:0] fault_set_byte,
	input wire logic [15:0] fault_set_word,
	output logic [7:0] status_byte,
	output logic [15:0] status_word,
	output logic bus_timeout_enable,
	output logic timeout_off_flag
);
	import ssa_pkg::*;
	typedef enum {
		SSA_IDLE, SSA_RX, SSA_ACK, SSA_TX, SSA_MACK
	} ssa_dst_t;
	ssa_dst_t st_q;
	logic sda_s, scl_rise, scl_fall, start_det, stop_det, act;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [2:0] byte_q;
	logic rd_q;
	logic ara_q;
	logic do_ack_q;
	logic sda_oe_q;
	logic [7:0] ptr_q;
	logic [7:0] cfg1_q;
	logic [15:0] mask_q;
	logic [7:0] stb_q;
	logic [15:0] stw_q;
	logic [7:0] wlo_q;
	logic [7:0] cnt_q;
	logic [7:0] blk_q [0:SSA_H_MAXB-1];
	logic [31:0] to_q;
	logic clear_req;
	ssa_sync u_sync (
		.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(link.scl),
		.sda_in(link.sda), .scl_s(), .sda_s(sda_s),
		.scl_rise(scl_rise), .scl_fall(scl_fall),
		.start_det(start_det), .stop_det(stop_det), .activity(act)
	);
	wire logic [7:0] stb_q_eff = stb_q & ~mask_q[7:0];
	wire logic [15:0] stw_q_eff = stw_q & ~mask_q;
	wire logic alert_on = (|(stb_q_eff & ~(8'h01 << SSA_STB_EXCL_BIT)))
		| (|(stw_q_eff & ~(16'h0001 << SSA_STW_EXCL_BIT)));
	assign link.alert_dev_oe = alert_on;
	assign link.sda_dev_oe = sda_oe_q;
	assign status_byte = stb_q;
	assign status_word = stw_q;
	assign bus_timeout_enable = cfg1_q[SSA_CFG1_TO_BIT];
	assign timeout_off_flag = ~cfg1_q[SSA_CFG1_TO_BIT];
	wire logic timed_out = bus_timeout_enable && st_q != SSA_IDLE
		&& to_q >= 32'(TIMEOUT_CYC);
	wire logic [7:0] rx_byte = {sh_q[6:0], sda_s};
	wire logic addr_hit = rx_byte[7:1] == DEV_ADDR;
	wire logic ara_hit = rx_byte[7:1] == SSA_ARA_ADDR && rx_byte[0]
		&& alert_on;
	function automatic logic [7:0] rd_byte(input logic [7:0] p,
		input logic [2:0] n);
		logic [7:0] r;
		r = 8'h00;
		unique case (p)
			SSA_CFG1_OFF: r = cfg1_q;
			SSA_STATUS_BYTE_OFF: r = stb_q;
			SSA_STATUS_WORD_OFF: r = n == 3'h0 ? stw_q[7:0] : stw_q[15:8];
			SSA_MASK_OFF: r = n == 3'h0 ? mask_q[7:0] : mask_q[15:8];
			SSA_BLOCK_OFF: r = n == 3'h0 ? 8'(SSA_H_MAXB)
				: blk_q[2'(n - 3'h1)];
			default: r = 8'h00;
		endcase
		return r;
	endfunction
	// Leading bit of a read byte, driven before the first clock rise
	function automatic logic rd_msb(input logic [7:0] p,
		input logic [2:0] n);
		logic [7:0] r;
		r = rd_byte(p, n);
		return r[7];
	endfunction
	assign clear_req = stop_det && st_q != SSA_IDLE && !rd_q
		&& byte_q == 3'h2 && ptr_q == SSA_CMD_CLEAR;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || act)
			to_q <= '0;
		else if (to_q != '1)
			to_q <= to_q + 32'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			stb_q <= 8'h00;
			stw_q <= 16'h0000;
		end
		else if (clear_req)
		begin
			// A fault in the clearing cycle is kept
			stb_q <= fault_set_byte;
			stw_q <= fault_set_word;
		end
		else
		begin
			stb_q <= stb_q | fault_set_byte;
			stw_q <= stw_q | fault_set_word;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_q <= SSA_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			byte_q <= 3'h0;
			rd_q <= 1'b0;
			ara_q <= 1'b0;
			do_ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			ptr_q <= 8'h00;
			cfg1_q <= SSA_CFG1_RST;
			mask_q <= SSA_MASK_RST;
			wlo_q <= 8'h00;
			cnt_q <= 8'h00;
			for (int i = 0; i < SSA_H_MAXB; i++)
				blk_q[i] <= 8'h00;
		end
		else if (start_det)
		begin
			st_q <= SSA_RX;
			bit_q <= 4'h0;
			byte_q <= 3'h0;
			sda_oe_q <= 1'b0;
		end
		else if (stop_det || timed_out)
		begin
			st_q <= SSA_IDLE;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				SSA_IDLE: sda_oe_q <= 1'b0;
				SSA_RX:
					if (scl_rise)
					begin
						sh_q <= rx_byte;
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h7)
						begin
							do_ack_q <= 1'b1;
							if (byte_q == 3'h0)
							begin
								do_ack_q <= addr_hit | ara_hit;
								rd_q <= rx_byte[0];
								ara_q <= ara_hit && !addr_hit;
							end
							else if (byte_q == 3'h1)
								ptr_q <= rx_byte;
							else if (byte_q == 3'h2
								&& ptr_q == SSA_BLOCK_OFF)
								cnt_q <= rx_byte;
							else if (byte_q == 3'h2)
								wlo_q <= rx_byte;
							else if (ptr_q == SSA_BLOCK_OFF
								&& byte_q - 3'h3 < 3'(SSA_H_MAXB))
								blk_q[2'(byte_q - 3'h3)] <= rx_byte;
							if (byte_q == 3'h2 && ptr_q == SSA_CFG1_OFF)
								cfg1_q <= rx_byte;
							if (byte_q == 3'h3 && ptr_q == SSA_MASK_OFF)
								mask_q <= {rx_byte, wlo_q};
							st_q <= SSA_ACK;
						end
					end
				SSA_ACK:
					if (scl_fall && !sda_oe_q)
					begin
						sda_oe_q <= do_ack_q;
						if (!do_ack_q)
							st_q <= SSA_IDLE;
					end
					else if (scl_fall)
					begin
						bit_q <= 4'h0;
						byte_q <= byte_q == 3'h7 ? byte_q : byte_q + 3'h1;
						if (rd_q)
						begin
							sh_q <= ara_q ? {DEV_ADDR, 1'b1}
								: rd_byte(ptr_q, 3'h0);
							st_q <= SSA_TX;
							sda_oe_q <= ~(ara_q ? DEV_ADDR[6]
								: rd_msb(ptr_q, 3'h0));
						end
						else
						begin
							st_q <= SSA_RX;
							sda_oe_q <= 1'b0;
						end
					end
				SSA_TX:
					if (scl_rise && sda_s != sh_q[7])
					begin
						st_q <= SSA_IDLE;
						sda_oe_q <= 1'b0;
					end
					else if (scl_fall)
					begin
						bit_q <= bit_q + 4'h1;
						sh_q <= {sh_q[6:0], 1'b1};
						sda_oe_q <= bit_q == 4'h7 ? 1'b0 : ~sh_q[6];
						if (bit_q == 4'h7)
							st_q <= SSA_MACK;
					end
				SSA_MACK:
					if (scl_rise)
					begin
						if (sda_s || ara_q)
							st_q <= SSA_IDLE;
						else
							wlo_q <= {5'h00, byte_q};
					end
					else if (scl_fall)
					begin
						bit_q <= 4'h0;
						sh_q <= rd_byte(ptr_q, 3'(wlo_q));
						sda_oe_q <= ~rd_msb(ptr_q, 3'(wlo_q));
						byte_q <= byte_q + 3'h1;
						st_q <= SSA_TX;
					end
				default: st_q <= SSA_IDLE;
			endcase
		end
	end
endmodule

//--- rtl/ssa_host.sv
// Host end: bus master driven from Avalon-MM registers
`timescale 1ns/1ns
module ssa_host
(
	input wire logic clk_sys,
	input wire logic rst_n,
	ssa_if.host link,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import ssa_pkg::*;
	typedef enum {
		SSA_H_IDLE, SSA_H_START, SSA_H_BIT, SSA_H_STOP
	} ssa_hst_t;
	ssa_hst_t st_q;
	logic sda_s;
	logic rd_ok_q;
	logic [31:0] ctrl_q;
	logic [31:0] wdat_q;
	logic [31:0] rdat_q;
	logic [7:0] seq_q [0:7];
	logic [3:0] nb_q;
	logic [3:0] bi_q;
	logic [3:0] bit_q;
	logic [3:0] div_q;
	logic [1:0] ph_q;
	logic [7:0] sh_q;
	logic nack_q;
	logic restart_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic busy_q;
	logic [3:0] nrd_q;
	ssa_sync u_sync (
		.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(link.scl),
		.sda_in(link.sda), .scl_s(), .sda_s(sda_s),
		.scl_rise(), .scl_fall(),
		.start_det(), .stop_det(), .activity()
	);
	assign link.scl_host_oe = scl_oe_q;
	assign link.sda_host_oe = sda_oe_q;
	// One wait state so read data stands at the accepting edge
	wire logic rd_take = avs_read && !rd_ok_q;
	assign avs_waitrequest = rd_take;
	wire logic tick = div_q == 4'(SSA_HALF_BIT - 1);
	wire logic [6:0] adr = ctrl_q[14:8];
	wire logic [7:0] cmd = ctrl_q[23:16];
	wire logic [2:0] op = ctrl_q[3:1];
	wire logic go = avs_write && avs_address == SSA_H_CTRL
		&& avs_writedata[0] && !busy_q;
	wire logic in_rd = bi_q >= nb_q - nrd_q && nrd_q != 4'h0;
	wire logic last_rd = bi_q == nb_q - 4'h1;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			rd_ok_q <= 1'b0;
		else
			rd_ok_q <= rd_take;
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			avs_readdata <= 32'h0;
		else if (rd_take)
			unique case (avs_address)
				SSA_H_CTRL: avs_readdata <= ctrl_q;
				SSA_H_WDATA: avs_readdata <= wdat_q;
				SSA_H_STAT: avs_readdata <= {30'h0, nack_q, busy_q};
				SSA_H_RDATA: avs_readdata <= rdat_q;
				default: avs_readdata <= 32'h0;
			endcase
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || st_q == SSA_H_IDLE)
			div_q <= 4'h0;
		else
			div_q <= tick ? 4'h0 : div_q + 4'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_q <= SSA_H_IDLE;
			ctrl_q <= 32'h0;
			wdat_q <= 32'h0;
			rdat_q <= 32'h0;
			nb_q <= 4'h0;
			bi_q <= 4'h0;
			bit_q <= 4'h0;
			ph_q <= 2'h0;
			sh_q <= 8'h0;
			nack_q <= 1'b0;
			restart_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_q <= 1'b0;
			nrd_q <= 4'h0;
			for (int i = 0; i < 8; i++)
				seq_q[i] <= 8'h0;
		end
		else if (go)
		begin
			ctrl_q <= avs_writedata;
			busy_q <= 1'b1;
			nack_q <= 1'b0;
			rdat_q <= 32'h0;
			st_q <= SSA_H_START;
			ph_q <= 2'h0;
			bi_q <= 4'h0;
			seq_q[0] <= {avs_writedata[14:8],
				avs_writedata[3:1] == 3'(SSA_OP_ARA)};
			seq_q[1] <= avs_writedata[23:16];
			seq_q[2] <= wdat_q[7:0];
			seq_q[3] <= wdat_q[15:8];
			seq_q[4] <= wdat_q[23:16];
			seq_q[5] <= wdat_q[31:24];
			seq_q[6] <= {avs_writedata[14:8], 1'b1};
			seq_q[7] <= 8'h0;
			unique case (ssa_op_t'(avs_writedata[3:1]))
				SSA_OP_SEND: begin nb_q <= 4'h2; nrd_q <= 4'h0; end
				SSA_OP_WWORD: begin nb_q <= 4'h4; nrd_q <= 4'h0; end
				SSA_OP_WBLOCK: begin nb_q <= 4'h7; nrd_q <= 4'h0; end
				// Reads other than SSA_OP_ARA count the resent address as a byte of its own
				SSA_OP_RBYTE: begin nb_q <= 4'h4; nrd_q <= 4'h1; end
				SSA_OP_RWORD: begin nb_q <= 4'h5; nrd_q <= 4'h2; end
				SSA_OP_RBLOCK: begin nb_q <= 4'h4; nrd_q <= 4'h1; end
				SSA_OP_ARA: begin nb_q <= 4'h2; nrd_q <= 4'h1; end
				default: begin nb_q <= 4'h1; nrd_q <= 4'h0; end
			endcase
			if (avs_writedata[3:1] == 3'(SSA_OP_WBLOCK))
			begin
				seq_q[2] <= 8'h4;
				seq_q[3] <= wdat_q[7:0];
				seq_q[4] <= wdat_q[15:8];
				seq_q[5] <= wdat_q[23:16];
				seq_q[6] <= wdat_q[31:24];
			end
		end
		else
		begin
			if (avs_write && avs_address == SSA_H_WDATA)
				wdat_q <= avs_writedata;
			if (tick)
			begin
				ph_q <= ph_q + 2'h1;
				unique case (st_q)
					SSA_H_IDLE: ph_q <= 2'h0;
					SSA_H_START:
						unique case (ph_q)
							2'h0: begin sda_oe_q <= 1'b0; scl_oe_q <= 1'b0; end
							2'h1: sda_oe_q <= 1'b1;
							2'h2: scl_oe_q <= 1'b1;
							default:
							begin
								st_q <= SSA_H_BIT;
								bit_q <= 4'h0;
								ph_q <= 2'h0;
								sh_q <= restart_q ? seq_q[6] : seq_q[bi_q[2:0]];
							end
						endcase
					SSA_H_BIT:
						unique case (ph_q)
							2'h0: sda_oe_q <= bit_q == 4'h8
								? (in_rd && !last_rd)
								: (in_rd ? 1'b0 : ~sh_q[7]);
							2'h1: scl_oe_q <= 1'b0;
							2'h2:
							begin
								if (bit_q < 4'h8 && in_rd)
									rdat_q <= {rdat_q[30:0], sda_s};
								if (bit_q == 4'h8 && !in_rd && sda_s)
									nack_q <= 1'b1;
							end
							default:
							begin
								scl_oe_q <= 1'b1;
								ph_q <= 2'h0;
								sh_q <= {sh_q[6:0], 1'b0};
								bit_q <= bit_q + 4'h1;
								if (bit_q == 4'h8)
								begin
									bit_q <= 4'h0;
									bi_q <= bi_q + 4'h1;
									sh_q <= seq_q[3'(bi_q + 4'h1)];
									if (last_rd || nack_q)
										st_q <= SSA_H_STOP;
									else if (bi_q == 4'h1 && nrd_q != 4'h0
										&& op != 3'(SSA_OP_ARA))
									begin
										restart_q <= 1'b1;
										st_q <= SSA_H_START;
									end
									else
										restart_q <= 1'b0;
								end
							end
						endcase
					SSA_H_STOP:
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							default:
							begin
								st_q <= SSA_H_IDLE;
								busy_q <= 1'b0;
								restart_q <= 1'b0;
							end
						endcase
					default: st_q <= SSA_H_IDLE;
				endcase
			end
		end
	end
endmodule

//--- dv/ssa_assertions.sv
// Checker: timing and acknowledge properties on the two-wire link
`timescale 1ns/1ns
module ssa_assertions
#(
	parameter logic [6:0] DEV_ADDR = ssa_pkg::SSA_DEV_ADDR_RST
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_host_oe,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic alert_dev_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic alert_n
);
	import ssa_pkg::*;
	logic scl_q;
	logic sda_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [8:0] hold_q;
	wire rise_w = scl & ~scl_q;
	wire first_w = cnt_q == 4'h8;
	wire ara_w = sh_q[7:1] == SSA_ARA_ADDR;
	// Only the first byte after a start is decoded as an address
	always_ff @(posedge clk_sys)
	begin
		scl_q <= scl;
		sda_q <= sda;
		hold_q <= sda_dev_oe ? hold_q + 9'h001 : 9'h000;
		if (!rst_n || (scl & scl_q & sda_q & ~sda))
			cnt_q <= 4'h0;
		else if (rise_w && cnt_q != 4'h9)
			cnt_q <= cnt_q + 4'h1;
		if (rise_w && cnt_q < 4'h8)
			sh_q <= {sh_q[6:0], sda};
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_start;
		scl && scl_q && sda_q && !sda && sda_host_oe;
	endsequence
	sequence s_addr_ack;
		rise_w && first_w && sda_dev_oe;
	endsequence
	property p_sda_change;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	property p_no_early_ack;
		s_start |=> !sda_dev_oe throughout (##280 1'b1);
	endproperty
	property p_ack_addr;
		rise_w && first_w && !ara_w |-> sda_dev_oe == (sh_q[7:1] == DEV_ADDR);
	endproperty
	property p_ara_ack;
		rise_w && first_w && ara_w |-> sda_dev_oe == (sh_q[0] && !alert_n);
	endproperty
	property p_ack_release;
		s_addr_ack ##0 !sh_q[0] |-> ##[1:40] !sda_dev_oe;
	endproperty
	// A byte of zeros plus the ack is the longest legal hold
	property p_dev_hold;
		hold_q < 9'h1a0;
	endproperty
	property p_scl_high;
		$rose(scl) |-> !scl_host_oe [*8];
	endproperty
	property p_stop_idle;
		scl && scl_q && !sda_q && sda |=> !sda_dev_oe [*8];
	endproperty
	a_sda_change: assert property (p_sda_change)
		else $error("device moved data line while clock high");
	a_no_early_ack: assert property (p_no_early_ack)
		else $error("device drove data line during address");
	a_ack_addr: assert property (p_ack_addr)
		else $error("address acknowledge wrong");
	a_ara_ack: assert property (p_ara_ack)
		else $error("alert response acknowledge wrong");
	a_ack_release: assert property (p_ack_release)
		else $error("write address acknowledge not released");
	a_dev_hold: assert property (p_dev_hold)
		else $error("device held data line too long");
	a_scl_high: assert property (p_scl_high)
		else $error("clock high phase too short");
	a_stop_idle: assert property (p_stop_idle)
		else $error("device drove data line after stop");
endmodule

//--- dv/test_serial_slave_protocols_alert.sv
// Testbench: host and device ends joined over the two-wire link
`timescale 1ns/1ns
module test_serial_slave_protocols_alert;
	import ssa_pkg::*;
	localparam int TO_CYC = 2000;
	localparam logic [6:0] DA = SSA_DEV_ADDR_RST;
	logic clk_sys;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] fault_set_byte = 8'h00;
	logic [15:0] fault_set_word = 16'h0000;
	logic bus_timeout_enable;
	logic timeout_off_flag;
	logic te2;
	logic chk_on = 1'b0;
	logic [7:0] sb;
	logic [15:0] sw;
	logic [31:0] rdat;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int mismatches = 0;
	int num_checks = 0;
	ssa_if link();
	ssa_if link2();
	ssa_host ssa_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	ssa_dev #(.TIMEOUT_CYC(TO_CYC)) ssa_dev_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(link), .fault_set_byte(fault_set_byte),
		.fault_set_word(fault_set_word), .status_byte(sb), .status_word(sw),
		.bus_timeout_enable(bus_timeout_enable),
		.timeout_off_flag(timeout_off_flag));
	// Second device faces the bench, which breaks the bus on purpose
	ssa_dev #(.TIMEOUT_CYC(TO_CYC)) ssa_dev_inst_b (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(link2), .fault_set_byte(8'h00),
		.fault_set_word(16'h0000), .status_byte(), .status_word(),
		.bus_timeout_enable(te2), .timeout_off_flag());
	ssa_assertions #(.DEV_ADDR(DA)) ssa_assertions_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .scl_host_oe(link.scl_host_oe),
		.sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
		.alert_dev_oe(link.alert_dev_oe), .scl(link.scl), .sda(link.sda),
		.alert_n(link.alert_n));
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Read data stands at the edge that accepts the read
	always @(posedge clk_sys)
	begin
		if (avs_read && chk_on && avs_waitrequest === 1'b0)
			cmp(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
	end
	task automatic av(input logic rd, input logic [3:0] a,
		input logic [31:0] wd, input logic chk, input logic [31:0] ex,
		input logic [31:0] mk);
		@(posedge clk_sys);
		avs_read <= rd;
		avs_write <= ~rd;
		avs_address <= a;
		avs_writedata <= wd;
		chk_on <= chk;
		if (chk)
		begin
			exp_q.push_back(ex);
			msk_q.push_back(mk);
		end
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk_on <= 1'b0;
	endtask
	task automatic rd_exp(input logic [31:0] ex, input logic [31:0] mk);
		av(1'b1, SSA_H_RDATA, 32'h0, 1'b1, ex, mk);
	endtask
	task automatic run(input ssa_op_t op, input logic [6:0] a7,
		input logic [7:0] cmd, input logic [31:0] wd, input logic nk);
		av(1'b0, SSA_H_WDATA, wd, 1'b0, 32'h0, 32'h0);
		av(1'b0, SSA_H_CTRL, {8'h00, cmd, 1'b0, a7, 4'h0, op, 1'b1},
			1'b0, 32'h0, 32'h0);
		rdat = 32'h1;
		for (int i = 0; i < 3000 && rdat[0] !== 1'b0; i++)
			av(1'b1, SSA_H_STAT, 32'h0, 1'b0, 32'h0, 32'h0);
		cmp({30'h0, rdat[1:0]}, {30'h0, nk, 1'b0});
	endtask
	task automatic bb_bit(input logic b);
		link2.sda_host_oe <= ~b;
		repeat (5) @(posedge clk_sys);
		link2.scl_host_oe <= 1'b0;
		repeat (10) @(posedge clk_sys);
		link2.scl_host_oe <= 1'b1;
		repeat (5) @(posedge clk_sys);
	endtask
	task automatic bb_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bb_bit(b[i]);
	endtask
	task automatic bb_start();
		link2.sda_host_oe <= 1'b1;
		repeat (10) @(posedge clk_sys);
		link2.scl_host_oe <= 1'b1;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic bb_stop();
		link2.sda_host_oe <= 1'b1;
		repeat (10) @(posedge clk_sys);
		link2.scl_host_oe <= 1'b0;
		repeat (10) @(posedge clk_sys);
		link2.sda_host_oe <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic pulse(input logic [7:0] b, input logic [15:0] w);
		fault_set_byte <= b;
		fault_set_word <= w;
		@(posedge clk_sys);
		fault_set_byte <= 8'h00;
		fault_set_word <= 16'h0000;
		repeat (4) @(posedge clk_sys);
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end
	initial
	begin
		logic [15:0] m;
		logic [31:0] bd;
		link2.scl_host_oe = 1'b0;
		link2.sda_host_oe = 1'b0;
		void'($urandom(18875));
		// Bit 2 masked, bit 0 left open for the live alert
		m = (16'($urandom) | 16'h0004) & 16'hfffe;
		bd = $urandom;
		repeat (20) @(posedge clk_sys);
		// Reset release stands for supply valid; the 2 ms wait is cut
		rst_n <= 1'b1;
		cmp({30'h0, bus_timeout_enable, timeout_off_flag}, 32'h1);
		run(SSA_OP_WWORD, DA, SSA_MASK_OFF, {16'h0, m}, 1'b0);
		run(SSA_OP_RWORD, DA, SSA_MASK_OFF, 32'h0, 1'b0);
		rd_exp({16'h0, m[7:0], m[15:8]}, 32'hffff);
		pulse(8'h40, 16'h0804);
		cmp({8'h00, sb, sw}, 32'h00400804);
		cmp({31'h0, link.alert_n}, 32'h1);
		run(SSA_OP_RBYTE, DA, SSA_STATUS_BYTE_OFF, 32'h0, 1'b0);
		rd_exp(32'h40, 32'hff);
		run(SSA_OP_RWORD, DA, SSA_STATUS_WORD_OFF, 32'h0, 1'b0);
		rd_exp(32'h0408, 32'hffff);
		run(SSA_OP_ARA, SSA_ARA_ADDR, 8'h00, 32'h0, 1'b1);
		run(SSA_OP_WWORD, DA ^ 7'h01, SSA_MASK_OFF, 32'h0, 1'b1);
		pulse(8'h00, 16'h0001);
		cmp({31'h0, link.alert_n}, 32'h0);
		run(SSA_OP_ARA, SSA_ARA_ADDR, 8'h00, 32'h0, 1'b0);
		rd_exp({24'h0, DA, 1'b0}, 32'hfe);
		run(SSA_OP_SEND, DA, SSA_CMD_CLEAR, 32'h0, 1'b0);
		cmp({31'h0, link.alert_n}, 32'h1);
		cmp({8'h00, sb, sw}, 32'h0);
		run(SSA_OP_RBYTE, DA, SSA_STATUS_BYTE_OFF, 32'h0, 1'b0);
		rd_exp(32'h0, 32'hff);
		run(SSA_OP_WBLOCK, DA, SSA_BLOCK_OFF, bd, 1'b0);
		run(SSA_OP_RBLOCK, DA, SSA_BLOCK_OFF, 32'h0, 1'b0);
		rd_exp(32'h4, 32'hff);
		run(SSA_OP_WWORD, DA, SSA_CFG1_OFF, 32'h8, 1'b0);
		cmp({30'h0, bus_timeout_enable, timeout_off_flag}, 32'h2);
		run(SSA_OP_RBYTE, DA, SSA_CFG1_OFF, 32'h0, 1'b0);
		rd_exp(32'h08, 32'hff);
		// Stall in the ack bit: held while the timeout is off
		bb_start();
		bb_byte({DA, 1'b0});
		// Let go of the line so only the device's ack can hold it low
		link2.sda_host_oe <= 1'b0;
		@(posedge clk_sys);
		cmp({31'h0, link2.sda}, 32'h0);
		repeat (TO_CYC * 3 / 2) @(posedge clk_sys);
		cmp({31'h0, link2.sda}, 32'h0);
		bb_bit(1'b1);
		bb_byte(SSA_CFG1_OFF);
		bb_bit(1'b1);
		bb_byte(8'h08);
		bb_bit(1'b1);
		bb_byte(8'h00);
		bb_bit(1'b1);
		bb_stop();
		cmp({31'h0, te2}, 32'h1);
		bb_start();
		bb_byte({DA, 1'b0});
		link2.sda_host_oe <= 1'b0;
		@(posedge clk_sys);
		repeat (TO_CYC * 3 / 4) @(posedge clk_sys);
		cmp({31'h0, link2.sda}, 32'h0);
		repeat (TO_CYC / 2) @(posedge clk_sys);
		cmp({31'h0, link2.sda}, 32'h1);
		bb_stop();
		finish_test();
	end
endmodule
